// ===== crs_pkg.sv
package crs_pkg;
    // Register indices
    localparam logic [7:0] IDX_MEM_TEST = 8'h05;
    localparam logic [7:0] IDX_FS_WORD0 = 8'h06;
    localparam logic [7:0] IDX_FS_WORD1 = 8'h07;
    localparam logic [7:0] IDX_FS_WORD2 = 8'h08;
    localparam logic [7:0] IDX_FS_WORD3 = 8'h09;
    localparam logic [7:0] IDX_UC_ADDR_LOW = 8'h0C;
    localparam logic [7:0] IDX_UC_ADDR_HIGH = 8'h0D;
    localparam logic [7:0] IDX_UC_DATA_PORT = 8'h0E;
    localparam logic [7:0] IDX_VENDOR_PORT = 8'h0F;
    localparam logic [7:0] IDX_CROP_START_X = 8'h10;
    localparam logic [7:0] IDX_CROP_START_Y = 8'h11;
    localparam logic [7:0] IDX_CROP_END_X = 8'h12;
    localparam logic [7:0] IDX_CROP_END_Y = 8'h13;
    localparam logic [7:0] IDX_CAPT_WIDTH = 8'h14;
    localparam logic [7:0] IDX_CAPT_HEIGHT = 8'h15;
    // Field positions in mem_test_control and uc_dram_addr_high
    localparam int MT_TEST_EN_BIT = 7;
    localparam int MT_HOLD_BIT = 6;
    localparam int MT_SREF_BIT = 5;
    localparam int MT_DELAY_BIT = 4;
    localparam int MT_SEL_LSB = 0;
    localparam int AH_DIR_BIT = 8;
    // Writable bit masks
    localparam logic [15:0] MT_MASK = 16'h00F7;
    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [20:0] RST_OFS = 21'h00_0000;
    // Vendor string capacity in 16-bit words (128 bytes)
    localparam int VENDOR_BYTES = 128;
    localparam logic [6:0] VENDOR_WORDS = 7'(VENDOR_BYTES / 2);
    // Fast serial bit time
    localparam int CLK_PERIOD_NS = 40;
    localparam int FS_BIT_TIME_NS = 2500;
    localparam logic [5:0] FS_BIT_CYCLES = 6'(FS_BIT_TIME_NS / CLK_PERIOD_NS);
    localparam logic [4:0] FS_LAST_BIT = 5'h1F;
    // Fast serial engine states
    typedef enum logic [1:0] {
        FS_IDLE = 2'b01,
        FS_SHIFT = 2'b10
    } crs_fs_state_t;
endpackage

// ===== crs_ctrl_regs.sv
// Contract
// - Bit 7 enables memory controller test mode
// - Bit 6 holds DRAM controller operation
// - Bit 5 puts SDRAM into self refresh
// - Bit 4 delay test, only in test mode
// - Bits 2-0 select memory test function
// - Data pattern bits at even positions
// - Clock pattern bits at odd positions
// - Writing word3 shifts 32 bits, LSB first
// - 21-bit DRAM word offset across two registers
// - High bit 8 sets DRAM transfer direction
// - Data port carries one 16-bit word
// - Vendor port write-only, 128 bytes maximum
// - Vendor port refuses USB accesses
// - Crop start X counted from HS end
// - Crop start Y counted from VS end
// - Crop end X; later pixels dropped
// - Crop end Y; later lines dropped
// - Accumulator drops pixels and lines evenly
// - Enable bit picks fast or direct pins
// - One bit pair every 62 clocks (2.48 us)
// - Sync polarity defines inactive edges
`timescale 1ns/10ps
`default_nettype none
module crs_ctrl_regs
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [7:0] reg_index_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_from_usb_in,
    output logic [15:0] reg_rdata_out,
    // Memory controller controls
    output logic memctl_test_mode_out,
    output logic dram_hold_out,
    output logic self_refresh_enable_out,
    output logic sdram_delay_test_out,
    output logic [2:0] memctl_test_select_out,
    // Serial bus
    input wire logic fast_serial_write_enable_in,
    input wire logic direct_data_release_in,
    input wire logic direct_clock_release_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_out,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_out,
    output logic fast_serial_busy_out,
    // DRAM access port
    output logic dram_req_out,
    output logic dram_we_out,
    output logic [20:0] dram_addr_out,
    output logic [15:0] dram_wdata_out,
    input wire logic dram_ack_in,
    input wire logic [15:0] dram_rdata_in,
    // Vendor string sink
    output logic vendor_wr_out,
    output logic [15:0] vendor_data_out,
    output logic vendor_full_out,
    // Video timing and crop results
    input wire logic pix_valid_in,
    input wire logic horizontal_sync_in,
    input wire logic vertical_sync_in,
    input wire logic hsync_pol_in,
    input wire logic vsync_pol_in,
    output logic line_keep_out,
    output logic pixel_keep_out
);

    // All block state in one record
    typedef struct packed {
        logic [15:0] mtc;
        logic [15:0] fs0;
        logic [15:0] fs1;
        logic [15:0] fs2;
        logic [15:0] fs3;
        crs_fs_state_t fst;
        logic [4:0] fsbit;
        logic [5:0] fstick;
        logic sda_oe;
        logic scl_oe;
        logic [20:0] ofs;
        logic dir;
        logic [15:0] dbuf;
        logic req;
        logic we;
        logic [20:0] dadr;
        logic [15:0] wdat;
        logic [6:0] vcnt;
        logic vwr;
        logic [15:0] vdat;
        logic [11:0] sx;
        logic [11:0] ex;
        logic [10:0] sy;
        logic [10:0] ey;
        logic [10:0] cw;
        logic [10:0] ch;
        logic [15:0] rdata;
        logic hs_d;
        logic vs_d;
        logic [11:0] xc;
        logic [10:0] yc;
        logic [11:0] xacc;
        logic [10:0] yacc;
        logic line_keep;
        logic pix_keep;
    } crs_state_t;

    // Registered state and its next value
    crs_state_t s_q;
    crs_state_t s_d;
    // Decoded helpers
    logic [31:0] data_pat;
    logic [31:0] clk_pat;
    logic wr;
    logic rd;
    logic hs_end;
    logic vs_end;
    logic [12:0] xsum;
    logic [11:0] ysum;
    logic [11:0] xspan;
    logic [10:0] yspan;
    logic [11:0] xbase;
    logic [10:0] ynext;

    // Unpack the interleaved pattern bits of the four words
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            data_pat[n] = s_q.fs0[2 * n];
            data_pat[n + 8] = s_q.fs1[2 * n];
            data_pat[n + 16] = s_q.fs2[2 * n];
            data_pat[n + 24] = s_q.fs3[2 * n];
            clk_pat[n] = s_q.fs0[2 * n + 1];
            clk_pat[n + 8] = s_q.fs1[2 * n + 1];
            clk_pat[n + 16] = s_q.fs2[2 * n + 1];
            clk_pat[n + 24] = s_q.fs3[2 * n + 1];
        end
    end

    // Access strobes and inactive sync edges
    assign wr = reg_wr_in;
    assign rd = reg_rd_in;
    assign hs_end = (s_q.hs_d == hsync_pol_in) && (horizontal_sync_in != hsync_pol_in);
    assign vs_end = (s_q.vs_d == vsync_pol_in) && (vertical_sync_in != vsync_pol_in);

    // Window spans for the accumulators
    assign xspan = s_q.ex - s_q.sx;
    assign yspan = s_q.ey - s_q.sy;

    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Pulses and scratch sums default low
        s_d.vwr = 1'b0;
        s_d.pix_keep = 1'b0;
        xsum = 13'h0000;
        ysum = 12'h000;
        xbase = 12'h000;
        ynext = 11'h000;

        // Register writes
        if (wr) begin
            unique case (reg_index_in)
                IDX_MEM_TEST: s_d.mtc = reg_wdata_in & MT_MASK;
                IDX_FS_WORD0: s_d.fs0 = reg_wdata_in;
                IDX_FS_WORD1: s_d.fs1 = reg_wdata_in;
                IDX_FS_WORD2: s_d.fs2 = reg_wdata_in;
                IDX_FS_WORD3: s_d.fs3 = reg_wdata_in;
                IDX_UC_ADDR_LOW: s_d.ofs[15:0] = reg_wdata_in;
                IDX_UC_ADDR_HIGH: begin
                    s_d.ofs[20:16] = reg_wdata_in[4:0];
                    s_d.dir = reg_wdata_in[AH_DIR_BIT];
                end
                IDX_CROP_START_X: s_d.sx = reg_wdata_in[11:0];
                IDX_CROP_START_Y: s_d.sy = reg_wdata_in[10:0];
                IDX_CROP_END_X: s_d.ex = reg_wdata_in[11:0];
                IDX_CROP_END_Y: s_d.ey = reg_wdata_in[10:0];
                IDX_CAPT_WIDTH: s_d.cw = reg_wdata_in[10:0];
                IDX_CAPT_HEIGHT: s_d.ch = reg_wdata_in[10:0];
                default: ;
            endcase
        end

        // Vendor string port: micro only, capped at 128 bytes
        if (wr && reg_index_in == IDX_VENDOR_PORT && !reg_from_usb_in) begin
            if (s_q.vcnt != VENDOR_WORDS) begin
                s_d.vwr = 1'b1;
                s_d.vdat = reg_wdata_in;
                s_d.vcnt = s_q.vcnt + 7'h01;
            end
        end

        // Read data mux; reserved bits read zero
        if (rd) begin
            unique case (reg_index_in)
                IDX_MEM_TEST: s_d.rdata = s_q.mtc;
                IDX_FS_WORD0: s_d.rdata = s_q.fs0;
                IDX_FS_WORD1: s_d.rdata = s_q.fs1;
                IDX_FS_WORD2: s_d.rdata = s_q.fs2;
                IDX_FS_WORD3: s_d.rdata = s_q.fs3;
                IDX_UC_ADDR_LOW: s_d.rdata = s_q.ofs[15:0];
                IDX_UC_ADDR_HIGH: s_d.rdata = {7'h00, s_q.dir, 3'h0, s_q.ofs[20:16]};
                IDX_UC_DATA_PORT: s_d.rdata = s_q.dbuf;
                IDX_CROP_START_X: s_d.rdata = {4'h0, s_q.sx};
                IDX_CROP_START_Y: s_d.rdata = {5'h00, s_q.sy};
                IDX_CROP_END_X: s_d.rdata = {4'h0, s_q.ex};
                IDX_CROP_END_Y: s_d.rdata = {5'h00, s_q.ey};
                IDX_CAPT_WIDTH: s_d.rdata = {5'h00, s_q.cw};
                IDX_CAPT_HEIGHT: s_d.rdata = {5'h00, s_q.ch};
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // DRAM port: a finished transfer advances the offset
        if (s_q.req && dram_ack_in) begin
            s_d.req = 1'b0;
            s_d.ofs = s_q.ofs + 21'h00_0001;
            if (!s_q.we) begin
                s_d.dbuf = dram_rdata_in;
            end
        end else if (!s_q.req) begin
            // A new transfer starts only while the port is free
            // Write mode: each data-port write stores one word
            if (wr && reg_index_in == IDX_UC_DATA_PORT && s_q.dir) begin
                s_d.req = 1'b1;
                s_d.we = 1'b1;
                s_d.dadr = s_q.ofs;
                s_d.wdat = reg_wdata_in;
            end else if ((!s_q.dir && rd && reg_index_in == IDX_UC_DATA_PORT) ||
                         (wr && reg_index_in == IDX_UC_ADDR_HIGH &&
                          !reg_wdata_in[AH_DIR_BIT])) begin
                // Read mode: selecting it or reading the port prefetches,
                // so the following read finds its word already buffered
                s_d.req = 1'b1;
                s_d.we = 1'b0;
                s_d.dadr = (wr ? {reg_wdata_in[4:0], s_q.ofs[15:0]} : s_q.ofs);
            end
        end

        // Fast serial engine
        unique case (s_q.fst)
            FS_IDLE: begin
                // Direct controls own the pins while idle
                s_d.sda_oe = !direct_data_release_in;
                s_d.scl_oe = !direct_clock_release_in;
            end
            FS_SHIFT: begin
                // Pull low for a zero bit, release for a one
                s_d.sda_oe = !data_pat[s_q.fsbit];
                s_d.scl_oe = !clk_pat[s_q.fsbit];
                if (s_q.fstick == FS_BIT_CYCLES - 6'h01) begin
                    s_d.fstick = 6'h00;
                    // Bit time over: next bit, or back to idle after the last
                    if (s_q.fsbit == FS_LAST_BIT) begin
                        s_d.fst = FS_IDLE;
                    end else begin
                        s_d.fsbit = s_q.fsbit + 5'h01;
                    end
                end else begin
                    s_d.fstick = s_q.fstick + 6'h01;
                end
            end
        endcase

        // Enable low aborts at once; a word3 write restarts the shift
        if (!fast_serial_write_enable_in) begin
            s_d.fst = FS_IDLE;
        end else if (wr && reg_index_in == IDX_FS_WORD3) begin
            s_d.fst = FS_SHIFT;
            s_d.fsbit = 5'h00;
            s_d.fstick = 6'h00;
        end

        // Sync history and position counters
        s_d.hs_d = horizontal_sync_in;
        s_d.vs_d = vertical_sync_in;
        ynext = s_q.yc + 11'h001;

        // Field boundaries restart both counters; line boundaries restart xc and advance yc
        if (vs_end) begin
            s_d.yc = 11'h000;
            s_d.xc = 12'h000;
            s_d.line_keep = 1'b0;
        end else if (hs_end) begin
            s_d.yc = ynext;
            s_d.xc = 12'h000;
            // A new line: decide whether it is kept
            if (ynext >= s_q.sy && ynext <= s_q.ey) begin
                // Vertical accumulator: keep height of span lines
                ysum = {1'b0, (ynext == s_q.sy) ? 11'h000 : s_q.yacc} + {1'b0, s_q.ch};
                if (ysum >= {1'b0, yspan}) begin
                    s_d.line_keep = 1'b1;
                    s_d.yacc = 11'(ysum - {1'b0, yspan});
                end else begin
                    s_d.line_keep = 1'b0;
                    s_d.yacc = ysum[10:0];
                end
            end else begin
                s_d.line_keep = 1'b0;
            end
        end else if (pix_valid_in) begin
            // One pixel per valid cycle, counted from the line start
            s_d.xc = s_q.xc + 12'h001;
            if (s_q.line_keep && s_q.xc >= s_q.sx && s_q.xc <= s_q.ex) begin
                // Horizontal accumulator: keep width of span pixels
                xbase = (s_q.xc == s_q.sx) ? 12'h000 : s_q.xacc;
                xsum = {1'b0, xbase} + {2'b00, s_q.cw};
                if (xsum >= {1'b0, xspan}) begin
                    s_d.pix_keep = 1'b1;
                    s_d.xacc = 12'(xsum - {1'b0, xspan});
                end else begin
                    s_d.xacc = xsum[11:0];
                end
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.fst <= FS_IDLE;
            s_q.mtc <= RST_WORD;
            s_q.ofs <= RST_OFS;
        end else begin
            s_q <= s_d;
        end
    end

    // Memory controller control outputs
    assign memctl_test_mode_out = s_q.mtc[MT_TEST_EN_BIT];
    assign dram_hold_out = s_q.mtc[MT_HOLD_BIT];
    assign self_refresh_enable_out = s_q.mtc[MT_SREF_BIT];
    assign sdram_delay_test_out = s_q.mtc[MT_DELAY_BIT] & s_q.mtc[MT_TEST_EN_BIT];
    assign memctl_test_select_out = s_q.mtc[MT_SEL_LSB +: 3];

    // Open-drain serial pins: only ever pull low
    assign serial_data_pin_out = 1'b0;
    assign serial_clock_pin_out = 1'b0;
    assign serial_data_pin_oe_out = s_q.sda_oe;
    assign serial_clock_pin_oe_out = s_q.scl_oe;
    assign fast_serial_busy_out = (s_q.fst == FS_SHIFT);

    // Remaining outputs
    assign reg_rdata_out = s_q.rdata;

    // DRAM request outputs
    assign dram_req_out = s_q.req;
    assign dram_we_out = s_q.we;
    assign dram_addr_out = s_q.dadr;
    assign dram_wdata_out = s_q.wdat;

    // Vendor sink and crop results
    assign vendor_wr_out = s_q.vwr;
    assign vendor_data_out = s_q.vdat;
    assign vendor_full_out = (s_q.vcnt == VENDOR_WORDS);
    assign line_keep_out = s_q.line_keep;
    assign pixel_keep_out = s_q.pix_keep;

endmodule
`default_nettype wire

// ===== crs_props.sv
`timescale 1ns/10ps
`default_nettype none
module crs_props
    import crs_pkg::*;
(
    // Clock, reset and register port
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_index_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_from_usb_in,
    // Memory controller controls
    input wire logic memctl_test_mode_out,
    input wire logic dram_hold_out,
    input wire logic self_refresh_enable_out,
    input wire logic sdram_delay_test_out,
    input wire logic [2:0] memctl_test_select_out,
    // Serial engine, DRAM port and vendor sink
    input wire logic fast_serial_write_enable_in,
    input wire logic fast_serial_busy_out,
    input wire logic dram_req_out,
    input wire logic dram_ack_in,
    input wire logic vendor_wr_out,
    input wire logic [15:0] vendor_data_out,
    input wire logic vendor_full_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic mt_wr;
    logic vs_wr;
    // Decoded writes to the control word and the vendor port
    assign mt_wr = reg_wr_in && reg_index_in == IDX_MEM_TEST;
    assign vs_wr = reg_wr_in && reg_index_in == IDX_VENDOR_PORT;
    a_test_mode_write: assert property (
        mt_wr |=> memctl_test_mode_out == $past(reg_wdata_in[7])) else $error("test mode lost");
    a_hold_write: assert property (
        mt_wr |=> dram_hold_out == $past(reg_wdata_in[6])) else $error("hold lost");
    a_sref_write: assert property (
        mt_wr |=> self_refresh_enable_out == $past(reg_wdata_in[5])) else $error("sref lost");
    a_delay_gated: assert property (
        sdram_delay_test_out |-> memctl_test_mode_out) else $error("delay test outside test");
    a_select_write: assert property (
        mt_wr |=> memctl_test_select_out == $past(reg_wdata_in[2:0])) else $error("select lost");
    a_serial_start: assert property (
        reg_wr_in && reg_index_in == IDX_FS_WORD3 && fast_serial_write_enable_in
        |=> fast_serial_busy_out) else $error("shift not started");
    a_serial_abort: assert property (
        !fast_serial_write_enable_in |=> !fast_serial_busy_out) else $error("shift not aborted");
    a_vendor_usb: assert property (
        vs_wr && reg_from_usb_in |=> !vendor_wr_out) else $error("usb vendor write taken");
    a_vendor_take: assert property (
        vs_wr && !reg_from_usb_in && !vendor_full_out
        |=> vendor_wr_out && vendor_data_out == $past(reg_wdata_in)) else $error("vendor lost");
    a_dram_release: assert property (
        dram_req_out && dram_ack_in |=> !dram_req_out) else $error("request held past ack");
endmodule
`default_nettype wire

// ===== crs_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
module crs_dram_model (
    // Clock, reset and pace
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic slow_in,
    // Request side
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [20:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic ack_out,
    output logic [15:0] rdata_out
);
    // Low eight offset bits index the store; unwritten words read as junk
    logic [15:0] mem [256];
    logic [255:0] seen;
    int wait_n;
    // One 16-bit word per request, answered at once or after a wait
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_out <= 1'b0;
            rdata_out <= 16'h5A5A;
            wait_n <= 0;
            seen <= '0;
        end else begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out; // Junk outside the answer cycle
            if (req_in && !ack_out && wait_n < (slow_in ? 6 : 0))
                wait_n <= wait_n + 1;
            else if (req_in && !ack_out) begin
                ack_out <= 1'b1;
                wait_n <= 0;
                if (we_in) begin
                    mem[addr_in[7:0]] <= wdata_in;
                    seen[addr_in[7:0]] <= 1'b1;
                end else begin
                    rdata_out <= seen[addr_in[7:0]] ? mem[addr_in[7:0]] : 16'hDEAD;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== ctrl_regs_serial_dram_port_crop_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module ctrl_regs_serial_dram_port_crop_test
    import crs_pkg::*;
;
    logic ref_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic reg_from_usb_in = 1'b0, fast_serial_write_enable_in = 1'b0, pix_valid_in = 1'b0;
    logic direct_data_release_in = 1'b1, direct_clock_release_in = 1'b0, slow = 1'b0;
    logic horizontal_sync_in = 1'b0, vertical_sync_in = 1'b1, hsync_pol_in = 1'b1;
    logic vsync_pol_in = 1'b0, dram_ack_in;
    logic [7:0] reg_index_in = 8'h00, mask;
    logic [15:0] reg_wdata_in = 16'h0000, dram_rdata_in, reg_rdata_out, w;
    logic [15:0] dram_wdata_out, vendor_data_out;
    logic [20:0] dram_addr_out;
    logic [2:0] memctl_test_select_out;
    logic memctl_test_mode_out, dram_hold_out, self_refresh_enable_out, sdram_delay_test_out;
    logic serial_data_pin_out, serial_data_pin_oe_out, serial_clock_pin_out;
    logic serial_clock_pin_oe_out, fast_serial_busy_out, dram_req_out, dram_we_out;
    logic vendor_wr_out, vendor_full_out, line_keep_out, pixel_keep_out;
    logic [31:0] dpat = 32'hA5C3_0F96, cpat = 32'h3C5A_9E01;
    logic [15:0] crop [6] = '{16'h0002, 16'h0001, 16'h0005, 16'h0002, 16'h0003, 16'h0001};
    int n_errors = 0, tests_run = 0, vend_cnt = 0;

    crs_ctrl_regs u_dut (.*);
    crs_dram_model u_mem (.ref_clk_in, .reset_n_in, .slow_in(slow), .req_in(dram_req_out),
        .we_in(dram_we_out), .addr_in(dram_addr_out), .wdata_in(dram_wdata_out),
        .ack_out(dram_ack_in), .rdata_out(dram_rdata_in));

    // Clock and vendor pulse counter
    initial forever #20 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (vendor_wr_out === 1'b1) vend_cnt <= vend_cnt + 1;

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    // One register access, strobe high for exactly one edge
    task automatic acc(input logic wr, input logic [7:0] i, input logic [15:0] d);
        step(1);
        reg_wr_in = wr;
        reg_rd_in = !wr;
        reg_index_in = i;
        reg_wdata_in = d;
        step(1);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] i, input logic [15:0] e);
        acc(1'b0, i, 16'h0000);
        step(1);
        `CHK("read data", e, reg_rdata_out)
    endtask
    task automatic dwait();
        for (int k = 0; k < 40 && dram_req_out !== 1'b0; k++) step(1);
        `CHK("dram idle", 1'b0, dram_req_out)
    endtask
    // Request must be up with the right offset and direction, then finish
    task automatic dreq(input logic [20:0] a, input logic wr, input logic [15:0] d);
        `CHK("dram req", 1'b1, dram_req_out)
        `CHK("dram addr", a, dram_addr_out)
        `CHK("dram dir", wr, dram_we_out)
        if (wr) `CHK("dram data", d, dram_wdata_out)
        dwait();
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        step(20000);
        n_errors++;
        wrap_up();
    end

    initial begin
        step(8);
        reset_n_in = 1'b1;
        rchk(IDX_MEM_TEST, RST_WORD);
        rchk(IDX_FS_WORD3, RST_WORD);
        rchk(8'h0A, 16'h0000);
        acc(1'b1, IDX_MEM_TEST, 16'hFFFF);
        rchk(IDX_MEM_TEST, MT_MASK);
        `CHK("test mode", 1'b1, memctl_test_mode_out)
        `CHK("hold", 1'b1, dram_hold_out)
        `CHK("self refresh", 1'b1, self_refresh_enable_out)
        `CHK("delay test", 1'b1, sdram_delay_test_out)
        for (int s = 0; s < 8; s++) begin
            acc(1'b1, IDX_MEM_TEST, 16'h0010 | 16'(s));
            step(1);
            `CHK("select", 3'(s), memctl_test_select_out)
            `CHK("delay gated", 1'b0, sdram_delay_test_out)
            `CHK("hold off", 1'b0, dram_hold_out)
        end
        $display("test control word done");
        acc(1'b1, IDX_CROP_END_X, 16'h0ABC);
        rchk(IDX_CROP_END_X, 16'h0ABC);
        for (int k = 0; k < 6; k++) begin
            acc(1'b1, 8'(IDX_CROP_START_X + k), crop[k]);
            rchk(8'(IDX_CROP_START_X + k), crop[k]);
        end
        // Negative vertical sync, positive horizontal sync
        vertical_sync_in = 1'b0;
        step(3);
        vertical_sync_in = 1'b1;
        step(2);
        for (int y = 1; y <= 4; y++) begin
            horizontal_sync_in = 1'b1;
            step(2);
            horizontal_sync_in = 1'b0;
            step(2);
            `CHK("line keep", y <= 2, line_keep_out)
            for (int x = 0; x < 9; x++) begin
                pix_valid_in = (x < 8);
                step(1);
                if (x < 8) mask[x] = pixel_keep_out;
            end
            `CHK("pixel keep", (y <= 2) ? 8'h3C : 8'h00, mask)
        end
        $display("test crop done");
        for (int k = 0; k < 4; k++) begin
            for (int b = 0; b < 8; b++) w[2*b +: 2] = {cpat[8*k+b], dpat[8*k+b]};
            acc(1'b1, 8'(IDX_FS_WORD0 + k), w);
            rchk(8'(IDX_FS_WORD0 + k), w);
        end
        `CHK("busy idle", 1'b0, fast_serial_busy_out)
        fast_serial_write_enable_in = 1'b1;
        acc(1'b1, IDX_FS_WORD3, w);
        step(32);
        `CHK("busy", 1'b1, fast_serial_busy_out)
        for (int n = 0; n < 32; n++) begin
            `CHK("data pin", !dpat[n], serial_data_pin_oe_out)
            `CHK("clock pin", !cpat[n], serial_clock_pin_oe_out)
            step(62);
        end
        `CHK("busy end", 1'b0, fast_serial_busy_out)
        `CHK("direct data", 1'b0, serial_data_pin_oe_out)
        `CHK("direct clock", 1'b1, serial_clock_pin_oe_out)
        `CHK("pin level", 2'b00, {serial_data_pin_out, serial_clock_pin_out})
        acc(1'b1, IDX_FS_WORD3, w);
        step(5);
        fast_serial_write_enable_in = 1'b0;
        step(2);
        `CHK("aborted", 1'b0, fast_serial_busy_out)
        $display("test fast serial done");
        reg_from_usb_in = 1'b1;
        acc(1'b1, IDX_VENDOR_PORT, 16'h1111);
        reg_from_usb_in = 1'b0;
        step(1);
        `CHK("usb vendor", 0, vend_cnt)
        for (int k = 0; k < 66; k++) acc(1'b1, IDX_VENDOR_PORT, 16'(k));
        step(1);
        `CHK("vendor count", 64, vend_cnt)
        `CHK("vendor full", 1'b1, vendor_full_out)
        `CHK("vendor last", 16'h003F, vendor_data_out)
        rchk(IDX_VENDOR_PORT, 16'h0000);
        $display("test vendor port done");
        slow = 1'b1;
        acc(1'b1, IDX_UC_ADDR_LOW, 16'h1234);
        acc(1'b1, IDX_UC_ADDR_HIGH, 16'h011F);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, IDX_UC_DATA_PORT, 16'hC0DE + 16'(k));
            dreq(21'h1F_1234 + 21'(k), 1'b1, 16'hC0DE + 16'(k));
        end
        rchk(IDX_UC_ADDR_LOW, 16'h1237);
        rchk(IDX_UC_ADDR_HIGH, 16'h011F);
        slow = 1'b0;
        acc(1'b1, IDX_UC_ADDR_LOW, 16'h1234);
        acc(1'b1, IDX_UC_ADDR_HIGH, 16'h001F);
        dreq(21'h1F_1234, 1'b0, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            rchk(IDX_UC_DATA_PORT, 16'hC0DE + 16'(k));
            dwait();
        end
        rchk(IDX_UC_ADDR_LOW, 16'h1238);
        $display("test dram port done");
        wrap_up();
    end
endmodule
bind crs_ctrl_regs crs_props u_props (.*);
`default_nettype wire
